// ### pm1es_status_bank.sv
/*
  Fixed-feature event status bank (bits 0..9) with its two I/O blocks,
  write-one-to-clear access, interrupt and wake generation.
  Assumes enables, state signals and firmware strobes come from logic on
  ref_clk; bus master request and the buttons arrive from pins.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - Status resets to zero, host read/write
// - Byte and aligned 16-bit accesses accepted
// - Bits split over two aligned blocks
// - Fixed-enable platform clears on working entry
// - Timer flag sets on each counter MSB toggle
// - Timer flag and enable raise interrupt
// - Bus master flag set on request, W1C
// - Only non-processor masters feed that flag
// - Firmware attention request sets global flag
// - Lock release with pending sets global flag
// - Reserved bits read back zero
// - Power button flag hardware set, W1C
// - Working: power flag and enable interrupt
// - Sleeping: power press always wakes
// - Held over four seconds: clear, soft-off
// - Wake press leaves power flag set
// - Sleep button flag hardware set, W1C
// - Working: sleep flag and enable interrupt
// - Sleeping: sleep press wakes if enabled
module pm1es_status_bank
  import pm1es_pkg::*;
#(
  parameter logic [pm1es_pkg::OVR_CNT_W-1:0] OVERRIDE_HOLD =
    pm1es_pkg::OVERRIDE_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [15:0] ioAddr,
  input wire logic ioRd,
  input wire logic ioWr,
  input wire pm1es_pkg::pm1es_size_t ioSize,
  input wire logic [15:0] ioWdata,
  output logic [15:0] ioRdata,
  output logic ioAck,
  input wire logic [pm1es_pkg::PM_TIMER_W-1:0] pmCounter,
  input wire logic busMasterReq,
  input wire logic fwAttentionReq,
  input wire logic fwLockRelease,
  input wire logic lockPending,
  input wire logic powerButtonPin,
  input wire logic sleepButtonPin,
  input wire logic timerCarryEnable,
  input wire logic globalEnable,
  input wire logic powerButtonEnable,
  input wire logic sleepButtonEnable,
  input wire logic sysWorking,
  input wire logic sysSleeping,
  input wire logic interruptEnableFixed,
  input wire logic enterWorking,
  output logic controlIrq,
  output logic wakeEvent,
  output logic forceSoftOff
);
  typedef struct packed {
    logic bmSyncA;
    logic bmSyncB;
    logic [STATUS_W-1:0] flags;
    logic [15:0] rdata;
    logic ack;
    logic irq;
    logic wake;
    logic softOff;
  } pm1es_bank_state_t;

  pm1es_bank_state_t st;
  pm1es_bank_state_t next_st;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  pm1es_btn_if powerEvt ();
  pm1es_btn_if sleepEvt ();
  logic carryPulse;
  logic hitA;
  logic hitB;
  logic accept;
  logic [15:0] laneMask;
  logic [15:0] bankMask;
  logic [15:0] wdataAligned;
  logic [15:0] readVec;
  logic [15:0] clrVec;
  logic [15:0] setVec;
  logic clearAll;

  // Status half of a block sits at the block base, one 16-bit word
  function automatic logic block_hit(input logic [15:0] addr,
                                     input logic [15:0] base);
    return addr[15:1] == base[15:1];
  endfunction

  pm1es_button #(
    .HAS_OVERRIDE(1'h1),
    .HOLD_CYCLES(OVERRIDE_HOLD)
  ) u_power (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .buttonPin(powerButtonPin),
    .evt(powerEvt.src)
  );

  pm1es_button #(
    .HAS_OVERRIDE(1'h0),
    .HOLD_CYCLES(OVERRIDE_HOLD)
  ) u_sleep (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .buttonPin(sleepButtonPin),
    .evt(sleepEvt.src)
  );

  pm1es_carry_watch u_carry (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .counterMsb(pmCounter[PM_TIMER_W-1]),
    .carryPulse(carryPulse)
  );

  assign hitA = block_hit(ioAddr, BLOCK_A_BASE);
  assign hitB = block_hit(ioAddr, BLOCK_B_BASE);
  assign bankMask = hitA ? BLOCK_A_MASK : (hitB ? BLOCK_B_MASK : 16'h0000);

  always_comb
  begin
    laneMask = 16'h0000;
    wdataAligned = ioWdata;
    if (ioSize == IO_WORD)
      laneMask = ioAddr[0] ? 16'h0000 : 16'hffff;
    else if (ioAddr[0])
    begin
      laneMask = 16'hff00;
      wdataAligned = {ioWdata[7:0], 8'h00};
    end
    else
    begin
      laneMask = 16'h00ff;
      wdataAligned = {8'h00, ioWdata[7:0]};
    end
  end

  // Misaligned words and unmapped addresses get no acknowledge
  assign accept = (ioRd || ioWr) && (hitA || hitB) && (laneMask != 16'h0000);

  // reserved and foreign-block bits read zero
  assign readVec = st.flags & bankMask & laneMask & IMPL_MASK;

  // only ones written clear, zeros leave bits alone
  assign clrVec = (accept && ioWr) ?
    (wdataAligned & laneMask & bankMask & IMPL_MASK) : 16'h0000;

  // wipe on working entry when the interrupt path is fixed on
  assign clearAll = enterWorking && interruptEnableFixed;

  always_comb
  begin
    setVec = 16'h0000;
    setVec[BIT_TIMER] = carryPulse;
    setVec[BIT_BUSMASTER] = st.bmSyncB;
    setVec[BIT_GLOBAL] = fwAttentionReq || (fwLockRelease && lockPending);
    // press sets the flag in any state, so a wake keeps it
    setVec[BIT_POWER] = powerEvt.press;
    setVec[BIT_SLEEP] = sleepEvt.press;
  end

  always_comb
  begin
    next_st = st;
    next_st.bmSyncA = busMasterReq;
    next_st.bmSyncB = st.bmSyncA;
    // set applied last so a new event beats any clear
    next_st.flags = st.flags & ~clrVec;
    if (powerEvt.override)
      next_st.flags[BIT_POWER] = 1'h0;
    if (clearAll)
      next_st.flags = STATUS_RESET;
    next_st.flags = (next_st.flags | setVec) & IMPL_MASK;
    next_st.ack = accept;
    if (accept && ioRd)
      next_st.rdata = ioAddr[0] && ioSize == IO_BYTE ?
        {8'h00, readVec[15:8]} : readVec;
    // level interrupt from flag and enable
    next_st.irq =
      (st.flags[BIT_TIMER] && timerCarryEnable) ||
      (st.flags[BIT_GLOBAL] && globalEnable) ||
      (sysWorking && st.flags[BIT_POWER] && powerButtonEnable) ||
      (sysWorking && st.flags[BIT_SLEEP] && sleepButtonEnable);
    next_st.wake = sysSleeping &&
      (powerEvt.press || (sleepEvt.press && sleepButtonEnable));
    next_st.softOff = powerEvt.override;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.flags <= STATUS_RESET;
    end
    else
      st <= next_st;
  end

  assign ioRdata = st.rdata;
  assign ioAck = st.ack;
  assign controlIrq = st.irq;
  assign wakeEvent = st.wake;
  assign forceSoftOff = st.softOff;

  property p_reset_zero;
    $fell(sys_rst) |-> (st.flags == STATUS_RESET && !ioAck);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("status not zero after reset");

  property p_access_ack;
    // Back-to-back accesses keep the acknowledge up for another cycle
    accept |=> ioAck ##1 (!ioAck || $past(accept));
  endproperty
  a_access_ack: assert property (p_access_ack)
    else $error("accepted access not acknowledged");

  property p_timer_set;
    carryPulse |=> st.flags[BIT_TIMER];
  endproperty
  a_timer_set: assert property (p_timer_set)
    else $error("timer flag missed a carry");

  property p_timer_irq;
    st.flags[BIT_TIMER] && timerCarryEnable |=> controlIrq;
  endproperty
  a_timer_irq: assert property (p_timer_irq)
    else $error("timer interrupt not raised");

  property p_bm_clear_only_w1c;
    $fell(st.flags[BIT_BUSMASTER]) |->
      $past(clrVec[BIT_BUSMASTER] || clearAll || sys_rst);
  endproperty
  a_bm_clear_only_w1c: assert property (p_bm_clear_only_w1c)
    else $error("bus master flag cleared without a write");

  property p_lock_release;
    fwLockRelease && lockPending |=> st.flags[BIT_GLOBAL];
  endproperty
  a_lock_release: assert property (p_lock_release)
    else $error("lock release did not set global flag");

  property p_reserved_zero;
    // Odd-byte reads move bits 15:8 down, so only even reads keep places
    ioAck && $past(ioRd && !ioAddr[0]) |->
      (ioRdata[7:6] == 2'h0 && ioRdata[3:1] == 3'h0 &&
       ioRdata[15:10] == 6'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read non-zero");

  property p_power_wake;
    sysSleeping && powerEvt.press |=> wakeEvent && st.flags[BIT_POWER];
  endproperty
  a_power_wake: assert property (p_power_wake)
    else $error("power press in sleep did not wake");

  property p_sleep_no_wake;
    sysSleeping && sleepEvt.press && !sleepButtonEnable &&
      !powerEvt.press |=> !wakeEvent;
  endproperty
  a_sleep_no_wake: assert property (p_sleep_no_wake)
    else $error("disabled sleep button woke the system");

  property p_override;
    powerEvt.override && !powerEvt.press |=>
      forceSoftOff && !st.flags[BIT_POWER];
  endproperty
  a_override: assert property (p_override)
    else $error("override did not clear flag or force soft-off");

  property p_set_wins;
    clrVec[BIT_BUSMASTER] && setVec[BIT_BUSMASTER] |=>
      st.flags[BIT_BUSMASTER];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a simultaneous set");

  property p_fixed_clear;
    clearAll && setVec == 16'h0000 |=> st.flags == STATUS_RESET;
  endproperty
  a_fixed_clear: assert property (p_fixed_clear)
    else $error("working entry did not clear status");

  c_carry: cover property (carryPulse ##1 st.flags[BIT_TIMER]);
  c_override: cover property (powerEvt.override ##1 forceSoftOff);
  c_wake: cover property (sysSleeping && sleepEvt.press ##1 wakeEvent);
  c_read: cover property (accept && ioRd ##1 ioAck && ioRdata != 16'h0000);
endmodule

// ### pm1es_pkg.sv
/*
  Shared constants for the power-management event status bank: bit
  positions, block bases and bit split, reset value, I/O sizes, timing.
  Assumes a single 200 MHz clock and 16-bit system I/O addresses.
*/
package pm1es_pkg;
  localparam int STATUS_W = 16;
  localparam int BIT_TIMER = 0;
  localparam int BIT_BUSMASTER = 4;
  localparam int BIT_GLOBAL = 5;
  localparam int BIT_POWER = 8;
  localparam int BIT_SLEEP = 9;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  // Bits this bank implements; everything else reads zero
  localparam logic [15:0] IMPL_MASK = 16'h0331;
  // Split of implemented bits between the two register blocks
  localparam logic [15:0] BLOCK_A_MASK = 16'h0031;
  localparam logic [15:0] BLOCK_B_MASK = 16'h0300;
  // Block bases in I/O space, each 32-bit aligned
  localparam logic [15:0] BLOCK_A_BASE = 16'h0400;
  localparam logic [15:0] BLOCK_B_BASE = 16'h0480;
  // Free-running counter width: 24 or 32
  localparam int PM_TIMER_W = 24;
  localparam int CLK_MHZ = 200;
  localparam int OVERRIDE_MS = 4000;
  localparam int OVR_CNT_W = 30;
  localparam logic [OVR_CNT_W-1:0] OVERRIDE_CYCLES =
    OVR_CNT_W'(OVERRIDE_MS * 1000 * CLK_MHZ);
  typedef enum logic {IO_BYTE, IO_WORD} pm1es_size_t;
endpackage

// ### pm1es_btn_if.sv
/*
  Carrier for the events of one conditioned button.
  Assumes source and sink share the one system clock.
*/
`timescale 1ns/1ps
interface pm1es_btn_if;
  logic press;
  logic override;
  modport src (output press, output override);
  modport dst (input press, input override);
endinterface

// ### pm1es_button.sv
/*
  Button conditioner: synchronises a raw button level, emits a press
  pulse on assertion and, optionally, an override pulse when held long.
  Assumes an active-high raw pin from outside the clock domain.
*/
`timescale 1ns/1ps
module pm1es_button
  import pm1es_pkg::*;
#(
  parameter bit HAS_OVERRIDE = 1'h1,
  parameter logic [pm1es_pkg::OVR_CNT_W-1:0] HOLD_CYCLES =
    pm1es_pkg::OVERRIDE_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic buttonPin,
  pm1es_btn_if.src evt
);
  typedef enum logic [1:0] {BTN_IDLE, BTN_HELD, BTN_DONE} pm1es_btn_mode_t;
  typedef struct packed {
    logic syncA;
    logic syncB;
    pm1es_btn_mode_t mode;
    logic [OVR_CNT_W-1:0] count;
    logic press;
    logic ovr;
  } pm1es_btn_state_t;

  pm1es_btn_state_t st;
  pm1es_btn_state_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.syncA = buttonPin;
    next_st.syncB = st.syncA;
    next_st.press = 1'h0;
    next_st.ovr = 1'h0;
    case (st.mode)
      BTN_IDLE:
      begin
        if (st.syncB)
        begin
          next_st.press = 1'h1;
          next_st.count = '0;
          next_st.mode = BTN_HELD;
        end
      end
      BTN_HELD:
      begin
        if (!st.syncB)
          next_st.mode = BTN_IDLE;
        else if (HAS_OVERRIDE && st.count == HOLD_CYCLES)
        begin
          // Held past the limit: fire once, then wait for release
          next_st.ovr = 1'h1;
          next_st.mode = BTN_DONE;
        end
        else
          next_st.count = st.count + 1'h1;
      end
      BTN_DONE:
      begin
        if (!st.syncB)
          next_st.mode = BTN_IDLE;
      end
      default:
        next_st.mode = BTN_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign evt.press = st.press;
  assign evt.override = st.ovr;
endmodule

// ### pm1es_carry_watch.sv
/*
  Detects every change of the counter's most significant bit and gives
  a one-cycle pulse. Assumes the counter runs on the same clock.
*/
`timescale 1ns/1ps
module pm1es_carry_watch
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic counterMsb,
  output logic carryPulse
);
  typedef struct packed {
    logic prevMsb;
    logic primed;
    logic pulse;
  } pm1es_carry_state_t;

  pm1es_carry_state_t st;
  pm1es_carry_state_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.prevMsb = counterMsb;
    next_st.primed = 1'h1;
    // No compare on the first cycle, prevMsb is not yet meaningful
    next_st.pulse = st.primed && (counterMsb != st.prevMsb);
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign carryPulse = st.pulse;
endmodule

// ### pm1es_host_model.sv
/*
  Host software model: byte and word I/O cycles on the status bank.
  Assumes a one-cycle strobe and an acknowledge one cycle after it.
*/
`timescale 1ns/1ps
module pm1es_host_model
  import pm1es_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [15:0] ioRdata,
  input wire logic ioAck,
  output logic [15:0] ioAddr,
  output logic ioRd,
  output logic ioWr,
  output pm1es_pkg::pm1es_size_t ioSize,
  output logic [15:0] ioWdata
);
  initial
  begin
    {ioAddr, ioWdata} = 32'h0000_0000;
    {ioRd, ioWr} = 2'h0;
    ioSize = IO_BYTE;
  end

  task automatic access(input logic wr, input logic [15:0] a,
    input pm1es_size_t s, input logic [15:0] d,
    output logic [15:0] q, output logic ack);
    @(posedge ref_clk);
    #1;
    ioAddr = a;
    ioSize = s;
    ioWdata = d;
    ioRd = !wr;
    ioWr = wr;
    @(posedge ref_clk);
    #1;
    ioRd = 1'h0;
    ioWr = 1'h0;
    // Released data is inverted so a stale value cannot pass for fresh
    ioWdata = ~d;
    ack = ioAck;
    q = ioRdata;
  endtask

  task automatic clearAll();
    logic [15:0] q;
    logic ack;
    access(1'h1, BLOCK_A_BASE, IO_WORD, IMPL_MASK & BLOCK_A_MASK, q, ack);
    access(1'h1, BLOCK_B_BASE, IO_WORD, IMPL_MASK & BLOCK_B_MASK, q, ack);
  endtask
endmodule

// ### pm1es_status_bank_tb_top.sv
/*
  Self-checking bench for the event status bank: host cycles, events,
  buttons, override and working entry.
  Assumes the host model drives the I/O port and a short override hold.
*/
`timescale 1ns/1ps
module pm1es_status_bank_tb_top;
  import pm1es_pkg::*;
  localparam logic [15:0] A = BLOCK_A_BASE;
  localparam logic [15:0] B = BLOCK_B_BASE;
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [15:0] ioAddr, ioWdata, ioRdata, q;
  logic ioRd, ioWr, ioAck, ack, controlIrq, wakeEvent, forceSoftOff;
  pm1es_size_t ioSize;
  logic [PM_TIMER_W-1:0] pmCounter = '0;
  logic busMasterReq, fwAttentionReq, fwLockRelease, lockPending;
  logic powerButtonPin, sleepButtonPin, timerCarryEnable, globalEnable;
  logic powerButtonEnable, sleepButtonEnable, sysWorking, sysSleeping;
  logic interruptEnableFixed, enterWorking;
  int errCount = 0;
  int numChecks = 0;
  int wakes, softs;

  always #2.5 ref_clk = ~ref_clk;

  pm1es_status_bank #(.OVERRIDE_HOLD(30'h14)) pm1es_status_bank_inst (
    .ref_clk, .sys_rst, .ioAddr, .ioRd, .ioWr, .ioSize, .ioWdata,
    .ioRdata, .ioAck, .pmCounter, .busMasterReq, .fwAttentionReq,
    .fwLockRelease, .lockPending, .powerButtonPin, .sleepButtonPin,
    .timerCarryEnable, .globalEnable, .powerButtonEnable,
    .sleepButtonEnable, .sysWorking, .sysSleeping,
    .interruptEnableFixed, .enterWorking, .controlIrq, .wakeEvent,
    .forceSoftOff);

  pm1es_host_model pm1es_host_model_inst (
    .ref_clk, .ioRdata, .ioAck, .ioAddr, .ioRd, .ioWr, .ioSize,
    .ioWdata);

  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    numChecks++;
    if (g !== e)
    begin
      errCount++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic irqIs(input logic e);
    chk("irq", {15'h0000, e}, {15'h0000, controlIrq});
  endtask

  task automatic rd(input logic [15:0] a, input pm1es_size_t s,
    input logic [15:0] e, input string n);
    pm1es_host_model_inst.access(1'h0, a, s, 16'h0000, q, ack);
    chk("ack", 16'h0001, {15'h0000, ack});
    chk(n, e, q);
  endtask

  task automatic wr(input logic [15:0] a, input pm1es_size_t s,
    input logic [15:0] d);
    pm1es_host_model_inst.access(1'h1, a, s, d, q, ack);
    chk("ack", 16'h0001, {15'h0000, ack});
  endtask

  task automatic noAck(input logic [15:0] a, input pm1es_size_t s);
    pm1es_host_model_inst.access(1'h0, a, s, 16'h0000, q, ack);
    chk("refused ack", 16'h0000, {15'h0000, ack});
  endtask

  task automatic flags(input logic [15:0] e, input string n);
    rd(A, IO_WORD, e & BLOCK_A_MASK, n);
    rd(B, IO_WORD, e & BLOCK_B_MASK, n);
  endtask

  // Counts wake and soft-off pulses over the hold and a short tail
  task automatic press(input logic slp, input int hold);
    wakes = 0;
    softs = 0;
    for (int i = 0; i < hold + 8; i++)
    begin
      powerButtonPin = !slp && (i < hold);
      sleepButtonPin = slp && (i < hold);
      step(1);
      wakes += (wakeEvent === 1'h1);
      softs += (forceSoftOff === 1'h1);
    end
  endtask

  task automatic pulseEntry();
    enterWorking = 1'h1;
    step(1);
    enterWorking = 1'h0;
    step(1);
  endtask

  task automatic testReset();
    flags(16'h0000, "reset value");
    noAck(16'h0500, IO_WORD);
    noAck(A + 16'h0001, IO_WORD);
    $display("reset test done");
  endtask

  task automatic testTimer();
    pmCounter[PM_TIMER_W-1] = 1'h1;
    step(4);
    flags(16'h0001, "timer rise");
    wr(A, IO_BYTE, 16'h0000);
    flags(16'h0001, "zero write");
    timerCarryEnable = 1'h1;
    step(2);
    irqIs(1'h1);
    wr(A, IO_BYTE, 16'h0001);
    step(2);
    irqIs(1'h0);
    timerCarryEnable = 1'h0;
    pmCounter[PM_TIMER_W-1] = 1'h0;
    step(4);
    flags(16'h0001, "timer fall");
    wr(A, IO_WORD, 16'h0001);
    $display("timer test done");
  endtask

  task automatic testBus();
    busMasterReq = 1'h1;
    step(2);
    busMasterReq = 1'h0;
    step(6);
    flags(16'h0010, "bus master");
    wr(A, IO_BYTE, 16'h0010);
    flags(16'h0000, "bus master clear");
    $display("bus master test done");
  endtask

  task automatic testGlobal();
    fwAttentionReq = 1'h1;
    step(1);
    fwAttentionReq = 1'h0;
    globalEnable = 1'h1;
    step(2);
    irqIs(1'h1);
    rd(A, IO_WORD, 16'h0020, "reserved zero");
    rd(A + 16'h0001, IO_BYTE, 16'h0000, "other block");
    wr(A, IO_BYTE, 16'h0020);
    globalEnable = 1'h0;
    fwLockRelease = 1'h1;
    step(1);
    fwLockRelease = 1'h0;
    step(2);
    flags(16'h0000, "release idle");
    lockPending = 1'h1;
    fwLockRelease = 1'h1;
    step(1);
    fwLockRelease = 1'h0;
    step(2);
    flags(16'h0020, "release pending");
    pulseEntry();
    flags(16'h0020, "entry not fixed");
    interruptEnableFixed = 1'h1;
    pulseEntry();
    flags(16'h0000, "entry fixed");
    interruptEnableFixed = 1'h0;
    $display("global test done");
  endtask

  task automatic testPower();
    sysWorking = 1'h1;
    powerButtonEnable = 1'h1;
    press(1'h0, 6);
    rd(B + 16'h0001, IO_BYTE, 16'h0001, "power flag");
    irqIs(1'h1);
    wr(B + 16'h0001, IO_BYTE, 16'h0001);
    step(2);
    irqIs(1'h0);
    flags(16'h0000, "power clear");
    sysWorking = 1'h0;
    sysSleeping = 1'h1;
    powerButtonEnable = 1'h0;
    press(1'h0, 6);
    chk("power wake", 16'h0001, 16'(wakes));
    flags(16'h0100, "wake flag");
    wr(B, IO_WORD, 16'h0100);
    press(1'h0, 40);
    chk("soft off", 16'h0001, 16'(softs));
    flags(16'h0000, "override clear");
    $display("power test done");
  endtask

  task automatic testSleep();
    press(1'h1, 6);
    chk("sleep no wake", 16'h0000, 16'(wakes));
    flags(16'h0200, "sleep flag");
    sleepButtonEnable = 1'h1;
    press(1'h1, 6);
    chk("sleep wake", 16'h0001, 16'(wakes));
    sysSleeping = 1'h0;
    sysWorking = 1'h1;
    step(2);
    irqIs(1'h1);
    wr(B + 16'h0001, IO_BYTE, 16'h0002);
    step(2);
    irqIs(1'h0);
    flags(16'h0000, "sleep clear");
    $display("sleep test done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    {busMasterReq, fwAttentionReq, fwLockRelease, lockPending} = 4'h0;
    {powerButtonPin, sleepButtonPin, timerCarryEnable} = 3'h0;
    {globalEnable, powerButtonEnable, sleepButtonEnable} = 3'h0;
    {sysWorking, sysSleeping, interruptEnableFixed} = 3'h0;
    enterWorking = 1'h0;
    repeat (2) @(posedge ref_clk);
    #1;
    sys_rst = 1'h0;
    testReset();
    testTimer();
    testBus();
    testGlobal();
    testPower();
    testSleep();
    pm1es_host_model_inst.clearAll();
    results();
  end

  // About forty times the expected run
  initial
  begin
    #50000;
    errCount++;
    $display("watchdog expired");
    results();
  end
endmodule
